// File: pkg/vpac_defs.vh
// Register offsets, field positions and reset values of the video pre-amp control bank
// Summary of operation
// - All adjustable video stages and external DAC levels set only via the I2C bus; this bank holds no DAC level registers.
// - One 7-bit contrast value at offset 03h drives all three channels' contrast.
// - Contrast code zero gives -20 dB attenuation; all ones gives none.
// - Gain registers at 00h, 01h, 02h each steer only their own channel.
// - Gain registers are 7 bits; code zero gives -10 dB attenuation.
// - Bits 0 to 2 of register 08 drive the output black-level offset stage.
// - Offset field decodes into 8 distinct black levels from 0.75V to 1.55V.
// - Bits 3 and 4 of register 08h select one of four OSD levels.
// - Both OSD contrast bits one gives highest level; both zero gives lowest.
// - OSD select high routes OSD to the mixer; low routes video.
// - DC restoration is enabled only while the clamp pulse input is high.
`ifndef VPAC_DEFS_VH
`define VPAC_DEFS_VH
// ****************************************
// Register map
// ****************************************
`define VPAC_ADDR_W        8
`define VPAC_OFS_GAIN_A    8'h00
`define VPAC_OFS_GAIN_B    8'h01
`define VPAC_OFS_GAIN_C    8'h02
`define VPAC_OFS_CONTRAST  8'h03
`define VPAC_OFS_OFFSET    8'h08
// ****************************************
// Fields and reset values
// ****************************************
`define VPAC_LEVEL_W       7
`define VPAC_BLACK_LSB     0
`define VPAC_BLACK_MSB     2
`define VPAC_OSD_LSB       3
`define VPAC_OSD_MSB       4
`define VPAC_RST_LEVEL     7'h7f
`define VPAC_RST_OFFSET    8'h00
`endif

// File: rtl/vpac_regs.v
// Control register bank of a three-channel video pre-amp, written over I2C
`timescale 1ns/1ps
`default_nettype none
`include "vpac_defs.vh"
module vpac_regs #(
	parameter [6:0] SLAVE_ADDR = 7'h6e
) (
	input  wire       clk,
	input  wire       rst,
	input  wire       scl_in,
	input  wire       sda_in,
	output reg        sda_out,
	output reg        sda_oe,
	input  wire       osd_select_in,
	input  wire       clamp_pulse_in,
	output reg  [6:0] gain_a,
	output reg  [6:0] gain_b,
	output reg  [6:0] gain_c,
	output reg  [6:0] contrast,
	output reg  [2:0] black_level_sel,
	output reg  [1:0] osd_level_sel,
	output reg        mixer_osd_sel,
	output reg        restore_en
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	// SCL and SDA idle high; their stages reset high so no false START follows reset
	reg [1:0] scl_s, sda_s, osd_s, clp_s;
	reg       scl_d, sda_d;
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			osd_s <= 2'h0;
			clp_s <= 2'h0;
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_s <= {scl_s[0], scl_in};
			sda_s <= {sda_s[0], sda_in};
			osd_s <= {osd_s[0], osd_select_in};
			clp_s <= {clp_s[0], clamp_pulse_in};
			scl_d <= scl_s[1];
			sda_d <= sda_s[1];
		end
	end
	// One extra stage of SCL and SDA feeds the edge and START/STOP detectors
	wire scl_rise = scl_s[1] & ~scl_d;
	wire scl_fall = ~scl_s[1] & scl_d;
	// START and STOP only count while SCL stays high across both samples
	wire start_c  = scl_s[1] & scl_d & sda_d & ~sda_s[1];
	wire stop_c   = scl_s[1] & scl_d & ~sda_d & sda_s[1];
	// ****************************************
	// Mixer select and clamp enable
	// ****************************************
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mixer_osd_sel <= 1'b0;
			restore_en    <= 1'b0;
		end else begin
			// Plain level follow-through; both pins are asynchronous to clk
			mixer_osd_sel <= osd_s[1];
			restore_en    <= clp_s[1];
		end
	end
	// ****************************************
	// I2C slave: address byte, register pointer, data bytes
	// ****************************************
	localparam ST_IDLE = 3'h0;
	localparam ST_DEV  = 3'h1;
	localparam ST_PTR  = 3'h2;
	localparam ST_DATA = 3'h3;
	localparam ST_RD   = 3'h4;
	localparam ST_ACK  = 3'h5;
	localparam ST_MACK = 3'h6;
	reg [2:0] state, ret;
	reg [3:0] bitcnt;
	reg [7:0] shreg;
	reg [7:0] ptr;
	reg [7:0] rd_byte;
	// Register 08 keeps all eight bits; the level registers drop bit 7
	reg [7:0] offset_reg;
	// Pointer decode shared by the read mux and the write path
	// Unmapped pointers give slot 7: writes are ACKed and dropped, reads give zero
	function [2:0] ptr_slot;
		input [7:0] p;
		case (p)
		`VPAC_OFS_GAIN_A:   ptr_slot = 3'h0;
		`VPAC_OFS_GAIN_B:   ptr_slot = 3'h1;
		`VPAC_OFS_GAIN_C:   ptr_slot = 3'h2;
		`VPAC_OFS_CONTRAST: ptr_slot = 3'h3;
		`VPAC_OFS_OFFSET:   ptr_slot = 3'h4;
		default:            ptr_slot = 3'h7;
		endcase
	endfunction
	// Read mux
	always @* begin
		case (ptr_slot(ptr))
		3'h0:    rd_byte = {1'b0, gain_a};
		3'h1:    rd_byte = {1'b0, gain_b};
		3'h2:    rd_byte = {1'b0, gain_c};
		3'h3:    rd_byte = {1'b0, contrast};
		3'h4:    rd_byte = offset_reg;
		default: rd_byte = 8'h00;
		endcase
	end
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			state      <= ST_IDLE;
			ret        <= ST_IDLE;
			bitcnt     <= 4'h0;
			shreg      <= 8'h00;
			ptr        <= 8'h00;
			sda_out    <= 1'b0;
			sda_oe     <= 1'b0;
			gain_a     <= `VPAC_RST_LEVEL;
			gain_b     <= `VPAC_RST_LEVEL;
			gain_c     <= `VPAC_RST_LEVEL;
			contrast   <= `VPAC_RST_LEVEL;
			offset_reg <= `VPAC_RST_OFFSET;
		end else if (start_c) begin
			state  <= ST_DEV;
			bitcnt <= 4'h0;
			sda_oe <= 1'b0;
		end else if (stop_c) begin
			state  <= ST_IDLE;
			sda_oe <= 1'b0;
		end else begin
			case (state)
			ST_IDLE: sda_oe <= 1'b0;
			ST_DEV, ST_PTR, ST_DATA: begin
				if (scl_rise) begin
					shreg  <= {shreg[6:0], sda_s[1]};
					bitcnt <= bitcnt + 4'h1;
				end else if (scl_fall && bitcnt == 4'h8) begin
					bitcnt <= 4'h0;
					if (state == ST_DEV) begin
						// Foreign address: stay off the bus until the next START
						if (shreg[7:1] != SLAVE_ADDR) begin
							state <= ST_IDLE;
						end else begin
							sda_oe <= 1'b1;
							state  <= ST_ACK;
							ret    <= shreg[0] ? ST_RD : ST_PTR;
						end
					end else if (state == ST_PTR) begin
						ptr    <= shreg;
						sda_oe <= 1'b1;
						state  <= ST_ACK;
						ret    <= ST_DATA;
					end else begin
						// Only the bus writes these; no other path reaches them
						case (ptr_slot(ptr))
						3'h0:    gain_a     <= shreg[6:0];
						3'h1:    gain_b     <= shreg[6:0];
						3'h2:    gain_c     <= shreg[6:0];
						3'h3:    contrast   <= shreg[6:0];
						3'h4:    offset_reg <= shreg;
						default: offset_reg <= offset_reg;
						endcase
						ptr    <= ptr + 8'h01;
						sda_oe <= 1'b1;
						state  <= ST_ACK;
						ret    <= ST_DATA;
					end
				end
			end
			ST_ACK: begin
				// SDA is only ever pulled low; a one is sent by letting go
				sda_out <= 1'b0;
				if (scl_fall) begin
					if (ret == ST_RD) begin
						shreg   <= rd_byte;
						sda_oe  <= ~rd_byte[7];
						bitcnt  <= 4'h1;
					end else begin
						sda_oe <= 1'b0;
					end
					state <= ret;
				end
			end
			ST_RD: begin
				// Open drain: drive only zeros, release for ones
				if (scl_fall) begin
					if (bitcnt == 4'h8) begin
						sda_oe <= 1'b0;
						ptr    <= ptr + 8'h01;
						state  <= ST_MACK;
					end else begin
						sda_oe <= ~shreg[3'h7 - bitcnt[2:0]];
						bitcnt <= bitcnt + 4'h1;
					end
				end
			end
			ST_MACK: begin
				// Master NACK ends the read; the bank then waits for STOP or START
				if (scl_rise) begin
					state <= sda_s[1] ? ST_IDLE : ST_ACK;
					ret   <= ST_RD;
				end
			end
			default: state <= ST_IDLE;
			endcase
		end
	end
	// ****************************************
	// Field outputs to the analog stages
	// ****************************************
	// Codes pass straight through: the analog stage maps 0 to deepest cut, max to none
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			black_level_sel <= 3'h0;
			osd_level_sel   <= 2'h0;
		end else begin
			// One clock behind the register, so the analog side sees whole words
			black_level_sel <= offset_reg[`VPAC_BLACK_MSB:`VPAC_BLACK_LSB];
			osd_level_sel   <= offset_reg[`VPAC_OSD_MSB:`VPAC_OSD_LSB];
		end
	end
endmodule
`default_nettype wire

// File: tb/test_video_preamp_control_regs.sv
// Self-checking bench of the video pre-amp control bank
`timescale 1ns/1ps
`default_nettype none
module test_video_preamp_control_regs;
	logic        clk, rst, osd, clamp, sda_oe, sda_out, scl, msda, ok, mo, re;
	logic [6:0]  ga, gb, gc, ct;
	logic [2:0]  bl;
	logic [1:0]  ol;
	logic [7:0]  ex [5];
	logic [7:0]  d;
	logic [31:0] rs, v;
	int          error_cnt, samples_checked, j;
	// Black-level code the master programs for the recommended driver; board dependent
	localparam logic [2:0] BLACK_REC = 3'h4;
	wire         sda_w = sda_oe ? sda_out : msda;
	vpac_regs dut (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out),
		.sda_oe(sda_oe), .osd_select_in(osd), .clamp_pulse_in(clamp), .gain_a(ga),
		.gain_b(gb), .gain_c(gc), .contrast(ct), .black_level_sel(bl),
		.osd_level_sel(ol), .mixer_osd_sel(mo), .restore_en(re));
	vpac_i2c_master m (.clk(clk), .sda_w(sda_w), .scl(scl), .sda(msda));
	function automatic logic [31:0] xs;
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic chk(input string n, input logic [7:0] s, e);
		samples_checked++;
		if (s !== e) begin
			error_cnt++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic cmp;
		chk("gain_a", {1'b0, ga}, ex[0]);
		chk("gain_b", {1'b0, gb}, ex[1]);
		chk("gain_c", {1'b0, gc}, ex[2]);
		chk("contrast", {1'b0, ct}, ex[3]);
		chk("black", {5'h0, bl}, {5'h0, ex[4][2:0]});
		chk("osd", {6'h0, ol}, {6'h0, ex[4][4:3]});
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		#300000;
		error_cnt++;
		final_report;
	end
	initial begin
		rst = 1'b1;
		osd = 1'b0;
		clamp = 1'b0;
		rs = 32'h0000cdbf;
		ex = '{8'h7f, 8'h7f, 8'h7f, 8'h7f, 8'h00};
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		// Foreign address and unmapped pointer must leave the bank alone
		m.wr(8'hde, 8'h00, 8'h11, ok);
		chk("nack", {7'h0, ok}, 8'h00);
		m.wr(8'hdc, 8'h05, 8'h22, ok);
		chk("ack", {7'h0, ok}, 8'h01);
		cmp;
		m.wr(8'hdc, 8'h08, {3'h0, 2'h3, BLACK_REC}, ok);
		ex[4] = {3'h0, 2'h3, BLACK_REC};
		repeat (4) @(posedge clk);
		#1;
		cmp;
		for (int k = 0; k < 15; k++) begin
			v = xs();
			j = (k < 5) ? k : (k < 10) ? k - 5 : int'(v[31:8] % 24'h5);
			d = (k < 5) ? 8'hff : (k < 10) ? 8'h00 : v[7:0];
			m.wr(8'hdc, (j < 4) ? j[7:0] : 8'h08, d, ok);
			ex[j] = d & ((j < 4) ? 8'h7f : 8'hff);
			v = xs();
			osd <= v[0];
			clamp <= v[1];
			repeat (4) @(posedge clk);
			#1;
			cmp;
			chk("mixer", {7'h0, mo}, {7'h0, osd});
			chk("restore", {7'h0, re}, {7'h0, clamp});
		end
		// Read every register back; level registers read bit 7 as zero
		for (int k = 0; k < 5; k++) begin
			m.rd(8'hdc, (k < 4) ? k[7:0] : 8'h08, d, ok);
			chk("read ack", {7'h0, ok}, 8'h01);
			chk("read data", d, ex[k]);
		end
		m.rd(8'hdc, 8'h05, d, ok);
		chk("read unmapped", d, 8'h00);
		final_report;
	end
endmodule
`default_nettype wire

// File: tb/vpac_i2c_master.sv
// Two-wire bus master model that programs the control bank
`timescale 1ns/1ps
`default_nettype none
module vpac_i2c_master (
	input  wire logic clk,
	input  wire logic sda_w,
	output var  logic scl,
	output var  logic sda
);
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// Long phases keep edges clear of the synchroniser delay
	task automatic hb;
		repeat (10) @(posedge clk);
	endtask
	task automatic bt(input logic b);
		sda <= b;
		hb;
		scl <= 1'b1;
		hb;
		scl <= 1'b0;
		hb;
	endtask
	// Release SDA for the ninth clock and look for the pull-down while SCL is high
	task automatic ak(inout logic ok);
		sda <= 1'b1;
		hb;
		scl <= 1'b1;
		hb;
		ok &= !sda_w;
		scl <= 1'b0;
		hb;
	endtask
	// Settings reach the bank over SDA and SCL only
	task automatic wr(input logic [7:0] a, p, d, output logic ok);
		logic [23:0] f;
		f = {a, p, d};
		ok = 1'b1;
		sda <= 1'b0;
		hb;
		scl <= 1'b0;
		hb;
		for (int i = 23; i >= 0; i--) begin
			bt(f[i]);
			if (i % 8 == 0) begin
				ak(ok);
			end
		end
		sda <= 1'b0;
		hb;
		scl <= 1'b1;
		hb;
		sda <= 1'b1;
		hb;
	endtask
	// Pointer write, repeated START, one byte read back, then NACK and STOP
	task automatic rd(input logic [7:0] a, p, output logic [7:0] d, output logic ok);
		logic [15:0] f;
		f = {a, p};
		ok = 1'b1;
		d = 8'h00;
		sda <= 1'b0;
		hb;
		scl <= 1'b0;
		hb;
		for (int i = 15; i >= 0; i--) begin
			bt(f[i]);
			if (i % 8 == 0) begin
				ak(ok);
			end
		end
		sda <= 1'b1;
		hb;
		scl <= 1'b1;
		hb;
		sda <= 1'b0;
		hb;
		scl <= 1'b0;
		hb;
		for (int i = 7; i >= 1; i--) begin
			bt(a[i]);
		end
		bt(1'b1);
		ak(ok);
		for (int i = 7; i >= 0; i--) begin
			sda <= 1'b1;
			hb;
			scl <= 1'b1;
			hb;
			d[i] = sda_w;
			scl <= 1'b0;
			hb;
		end
		bt(1'b1);
		sda <= 1'b0;
		hb;
		scl <= 1'b1;
		hb;
		sda <= 1'b1;
		hb;
	endtask
endmodule
`default_nettype wire

// File: tb/vpac_regs_asserts.sv
// Port checker of the video pre-amp control bank
`timescale 1ns/1ps
`default_nettype none
module vpac_regs_chk (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       scl_in,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic       osd_select_in,
	input wire logic       clamp_pulse_in,
	input wire logic [6:0] gain_a,
	input wire logic [6:0] gain_b,
	input wire logic [6:0] gain_c,
	input wire logic [6:0] contrast,
	input wire logic [2:0] black_level_sel,
	input wire logic [1:0] osd_level_sel,
	input wire logic       mixer_osd_sel,
	input wire logic       restore_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Updates land only in the SCL low phase
	sequence scl_low2;
		!scl_in ##1 !scl_in;
	endsequence
	chk_mix_lag: assert property (mixer_osd_sel == $past(osd_select_in, 3))
		else $error("mixer select lag wrong");
	chk_clamp_lag: assert property (restore_en == $past(clamp_pulse_in, 3))
		else $error("restore enable lag wrong");
	chk_reset_vals: assert property ($fell(rst) |-> {gain_a, contrast} == 14'h3fff)
		else $error("reset value wrong");
	chk_ack_low: assert property (sda_oe |-> !sda_out)
		else $error("sda driven high");
	chk_ack_edge: assert property ($rose(sda_oe) |-> scl_low2)
		else $error("ack outside scl low");
	chk_gain_quiet: assert property ($changed({gain_a, gain_b, gain_c}) |-> scl_low2)
		else $error("gain moved without write");
	chk_ctr_quiet: assert property ($changed(contrast) |-> scl_low2)
		else $error("contrast moved without write");
	chk_field_quiet: assert property ($changed({osd_level_sel, black_level_sel}) |-> scl_low2)
		else $error("offset field moved without write");
endmodule
bind vpac_regs vpac_regs_chk u_chk (.clk(clk), .rst(rst), .scl_in(scl_in), .sda_out(sda_out),
	.sda_oe(sda_oe), .osd_select_in(osd_select_in), .clamp_pulse_in(clamp_pulse_in),
	.gain_a(gain_a), .gain_b(gain_b), .gain_c(gain_c), .contrast(contrast),
	.black_level_sel(black_level_sel), .osd_level_sel(osd_level_sel),
	.mixer_osd_sel(mixer_osd_sel), .restore_en(restore_en));
`default_nettype wire
